// ==== rtl/crossing_iir_rms_power_detect.sv ====
// Purpose: two crossing IIR comparator paths and an RMS power detector behind an APB slave
// Assumes: tick is a one-cycle pulse per sample clock / 8 cycle, all inputs synchronous to pclk
// Notes:   zero wait state APB, unmapped or unaligned addresses answer with pslverr
`timescale 1ns/1ps
module crossing_iir_rms_power_detect
  import power_detect_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               tick,
  input  wire logic [1:0]         blk_high_hit,
  input  wire logic [1:0]         blk_low_hit,
  input  wire logic signed [15:0] rms_sample,
  output logic [1:0]              path0_flag_out,
  output logic [1:0]              path1_flag_out,
  output logic                    power_high_q,
  output logic                    power_low_q,
  output logic                    irq
);

  // -------------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------------
  function automatic logic [8:0] decode_idx(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    logic       ok;
    idx = a[9:2];
    ok  = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0);
    unique case (idx)
      IDX_FILT_SEL, IDX_P0_HI_LO, IDX_P0_HI_HI, IDX_P0_LO_LO, IDX_P0_LO_HI,
      IDX_P0_FORMAT, IDX_P1_HI_LO, IDX_P1_HI_HI, IDX_P1_LO_LO, IDX_P1_LO_HI,
      IDX_P1_FORMAT, IDX_HOLD_LO, IDX_HOLD_HI, IDX_RMS_EN, IDX_RMS_LEN,
      IDX_PWR_HI_LO, IDX_PWR_HI_HI, IDX_PWR_LO_LO, IDX_PWR_LO_HI,
      IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_LIVE: decode_idx = {ok, idx};
      default:                              decode_idx = {1'b0, idx};
    endcase
  endfunction : decode_idx

  function automatic logic signed [15:0] iir_step(input logic signed [15:0] y,
                                                  input logic signed [15:0] x,
                                                  input int               k);
    logic signed [16:0] diff;
    logic signed [16:0] sum;
    diff     = 17'(x) - 17'(y);
    sum      = 17'(y) + (diff >>> k);
    iir_step = sum[15:0];
  endfunction : iir_step

  // -------------------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------------------
  logic [8:0] dec;
  logic       hit;
  logic [7:0] idx;
  logic       wr_en;

  assign dec     = decode_idx(paddr);
  assign hit     = dec[8];
  assign idx     = dec[7:0];
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit;

  // -------------------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------------------
  logic        filter_input_select_q;
  logic [15:0] path0_upper_limit_q;
  logic [15:0] path0_lower_limit_q;
  logic [15:0] path1_upper_limit_q;
  logic [15:0] path1_lower_limit_q;
  logic        path0_wide_flag_sel_q;
  logic        path1_wide_flag_sel_q;
  logic [15:0] filter_flag_hold_count_q;
  logic        power_meter_on_q;
  logic [4:0]  power_avg_length_exp_q;
  logic [15:0] power_upper_limit_q;
  logic [15:0] power_lower_limit_q;
  logic [IRQ_W-1:0] irq_mask_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_input_select_q    <= 1'b0;
      path0_upper_limit_q      <= THR_RESET;
      path0_lower_limit_q      <= THR_RESET;
      path1_upper_limit_q      <= THR_RESET;
      path1_lower_limit_q      <= THR_RESET;
      path0_wide_flag_sel_q    <= 1'b0;
      path1_wide_flag_sel_q    <= 1'b0;
      filter_flag_hold_count_q <= THR_RESET;
      power_meter_on_q         <= 1'b0;
      power_avg_length_exp_q   <= 5'h00;
      power_upper_limit_q      <= THR_RESET;
      power_lower_limit_q      <= THR_RESET;
      irq_mask_q               <= '0;
    end
    else if (wr_en)
    begin
      unique case (idx)
        IDX_FILT_SEL:  filter_input_select_q           <= pwdata[0];
        IDX_P0_HI_LO:  path0_upper_limit_q[7:0]        <= pwdata[7:0];
        IDX_P0_HI_HI:  path0_upper_limit_q[15:8]       <= pwdata[7:0];
        IDX_P0_LO_LO:  path0_lower_limit_q[7:0]        <= pwdata[7:0];
        IDX_P0_LO_HI:  path0_lower_limit_q[15:8]       <= pwdata[7:0];
        IDX_P0_FORMAT: path0_wide_flag_sel_q           <= pwdata[0];
        IDX_P1_HI_LO:  path1_upper_limit_q[7:0]        <= pwdata[7:0];
        IDX_P1_HI_HI:  path1_upper_limit_q[15:8]       <= pwdata[7:0];
        IDX_P1_LO_LO:  path1_lower_limit_q[7:0]        <= pwdata[7:0];
        IDX_P1_LO_HI:  path1_lower_limit_q[15:8]       <= pwdata[7:0];
        IDX_P1_FORMAT: path1_wide_flag_sel_q           <= pwdata[0];
        IDX_HOLD_LO:   filter_flag_hold_count_q[7:0]   <= pwdata[7:0];
        IDX_HOLD_HI:   filter_flag_hold_count_q[15:8]  <= pwdata[7:0];
        IDX_RMS_EN:    power_meter_on_q                <= pwdata[0];
        IDX_RMS_LEN:   power_avg_length_exp_q          <= pwdata[4:0];
        IDX_PWR_HI_LO: power_upper_limit_q[7:0]        <= pwdata[7:0];
        IDX_PWR_HI_HI: power_upper_limit_q[15:8]       <= pwdata[7:0];
        IDX_PWR_LO_LO: power_lower_limit_q[7:0]        <= pwdata[7:0];
        IDX_PWR_LO_HI: power_lower_limit_q[15:8]       <= pwdata[7:0];
        IDX_IRQ_MASK:  irq_mask_q                      <= pwdata[IRQ_W-1:0];
        default:       ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // iir filters
  // -------------------------------------------------------------------------
  logic signed [15:0] filt_q [2];
  logic signed [15:0] filt_in [2];

  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (filter_input_select_q)
      begin
        if (blk_high_hit[p])
          filt_in[p] = FRAC_ONE;
        else if (!blk_low_hit[p])
          filt_in[p] = FRAC_MINUS1;
        else
          filt_in[p] = THR_RESET;
      end
      else
        filt_in[p] = blk_high_hit[p] ? FRAC_ONE : THR_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_q[0] <= THR_RESET;
      filt_q[1] <= THR_RESET;
    end
    else if (tick)
    begin
      filt_q[0] <= iir_step(filt_q[0], filt_in[0], IIR_SHIFT0);
      filt_q[1] <= iir_step(filt_q[1], filt_in[1], IIR_SHIFT1);
    end
  end

  // -------------------------------------------------------------------------
  // path comparators
  // -------------------------------------------------------------------------
  logic path0_peak;
  logic path1_peak;

  path_compare u_path0 (
    .pclk          (pclk),
    .presetn       (presetn),
    .tick          (tick),
    .filt          (filt_q[0]),
    .upper_limit   (path0_upper_limit_q),
    .lower_limit   (path0_lower_limit_q),
    .hold_count    (filter_flag_hold_count_q),
    .wide_flag_sel (path0_wide_flag_sel_q),
    .peak_flag_q   (path0_peak),
    .flag_out_q    (path0_flag_out)
  );

  path_compare u_path1 (
    .pclk          (pclk),
    .presetn       (presetn),
    .tick          (tick),
    .filt          (filt_q[1]),
    .upper_limit   (path1_upper_limit_q),
    .lower_limit   (path1_lower_limit_q),
    .hold_count    (filter_flag_hold_count_q),
    .wide_flag_sel (path1_wide_flag_sel_q),
    .peak_flag_q   (path1_peak),
    .flag_out_q    (path1_flag_out)
  );

  // -------------------------------------------------------------------------
  // rms power detector
  // -------------------------------------------------------------------------
  logic [4:0]  len_exp;
  logic [16:0] blk_last;
  logic [31:0] sq;
  logic [15:0] pwr;
  logic [32:0] acc_q;
  logic [32:0] acc_sum;
  logic [16:0] blk_cnt_q;
  logic [15:0] avg_q;
  logic        avg_valid_q;
  logic        block_end;

  assign len_exp   = (power_avg_length_exp_q > LEN_EXP_MAX) ? LEN_EXP_MAX : power_avg_length_exp_q;
  assign blk_last  = 17'((33'd1 << len_exp) - 33'd1);
  assign sq        = 32'(rms_sample * rms_sample);
  assign pwr       = (sq[31:PWR_SHIFT] > 18'h0FFFF) ? 16'hFFFF : sq[PWR_SHIFT+15:PWR_SHIFT];
  assign acc_sum   = acc_q + {17'h00000, pwr};
  assign block_end = tick && (blk_cnt_q == blk_last);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q     <= '0;
      blk_cnt_q <= '0;
    end
    else if (!power_meter_on_q)
    begin
      acc_q     <= '0;
      blk_cnt_q <= '0;
    end
    else if (block_end)
    begin
      acc_q     <= '0;
      blk_cnt_q <= '0;
    end
    else if (tick)
    begin
      acc_q     <= acc_sum;
      blk_cnt_q <= blk_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      avg_q       <= 16'h0000;
      avg_valid_q <= 1'b0;
    end
    else if (!power_meter_on_q)
    begin
      avg_q       <= 16'h0000;
      avg_valid_q <= 1'b0;
    end
    else if (block_end)
    begin
      avg_q       <= 16'(acc_sum >> len_exp);
      avg_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_high_q <= 1'b0;
      power_low_q  <= 1'b0;
    end
    else
    begin
      power_high_q <= power_meter_on_q && avg_valid_q && (avg_q > power_upper_limit_q);
      power_low_q  <= power_meter_on_q && avg_valid_q && (avg_q < power_lower_limit_q);
    end
  end

  // -------------------------------------------------------------------------
  // interrupts
  // -------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] events;
  logic             p0_peak_d1_q;
  logic             p1_peak_d1_q;
  logic             pwr_hi_d1_q;
  logic             pwr_lo_d1_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p0_peak_d1_q <= 1'b0;
      p1_peak_d1_q <= 1'b0;
      pwr_hi_d1_q  <= 1'b0;
      pwr_lo_d1_q  <= 1'b0;
    end
    else
    begin
      p0_peak_d1_q <= path0_peak;
      p1_peak_d1_q <= path1_peak;
      pwr_hi_d1_q  <= power_high_q;
      pwr_lo_d1_q  <= power_low_q;
    end
  end

  always_comb
  begin
    events             = '0;
    events[IRQ_P0_SET] = path0_peak && !p0_peak_d1_q;
    events[IRQ_P1_SET] = path1_peak && !p1_peak_d1_q;
    events[IRQ_PWR_HI] = power_high_q && !pwr_hi_d1_q;
    events[IRQ_PWR_LO] = power_low_q && !pwr_lo_d1_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= '0;
    else if (wr_en && idx == IDX_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | events;
    else
      irq_stat_q <= irq_stat_q | events;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // -------------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (hit)
      begin
        unique case (idx)
          IDX_FILT_SEL:  prdata[0]       <= filter_input_select_q;
          IDX_P0_HI_LO:  prdata[7:0]     <= path0_upper_limit_q[7:0];
          IDX_P0_HI_HI:  prdata[7:0]     <= path0_upper_limit_q[15:8];
          IDX_P0_LO_LO:  prdata[7:0]     <= path0_lower_limit_q[7:0];
          IDX_P0_LO_HI:  prdata[7:0]     <= path0_lower_limit_q[15:8];
          IDX_P0_FORMAT: prdata[0]       <= path0_wide_flag_sel_q;
          IDX_P1_HI_LO:  prdata[7:0]     <= path1_upper_limit_q[7:0];
          IDX_P1_HI_HI:  prdata[7:0]     <= path1_upper_limit_q[15:8];
          IDX_P1_LO_LO:  prdata[7:0]     <= path1_lower_limit_q[7:0];
          IDX_P1_LO_HI:  prdata[7:0]     <= path1_lower_limit_q[15:8];
          IDX_P1_FORMAT: prdata[0]       <= path1_wide_flag_sel_q;
          IDX_HOLD_LO:   prdata[7:0]     <= filter_flag_hold_count_q[7:0];
          IDX_HOLD_HI:   prdata[7:0]     <= filter_flag_hold_count_q[15:8];
          IDX_RMS_EN:    prdata[0]       <= power_meter_on_q;
          IDX_RMS_LEN:   prdata[4:0]     <= power_avg_length_exp_q;
          IDX_PWR_HI_LO: prdata[7:0]     <= power_upper_limit_q[7:0];
          IDX_PWR_HI_HI: prdata[7:0]     <= power_upper_limit_q[15:8];
          IDX_PWR_LO_LO: prdata[7:0]     <= power_lower_limit_q[7:0];
          IDX_PWR_LO_HI: prdata[7:0]     <= power_lower_limit_q[15:8];
          IDX_IRQ_STAT:  prdata[3:0]     <= irq_stat_q;
          IDX_IRQ_MASK:  prdata[3:0]     <= irq_mask_q;
          IDX_LIVE:      prdata[5:0]     <= {power_low_q, power_high_q, path1_peak, path0_peak, 2'b00};
          default:       ;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  rms_off_quiet_a : assert property (@(posedge pclk) disable iff (!presetn)
    !power_meter_on_q ##1 !power_meter_on_q |=> !power_high_q && !power_low_q)
    else $error("power flags active while detector off");

  block_len_a : assert property (@(posedge pclk) disable iff (!presetn)
    power_meter_on_q && tick |-> blk_cnt_q <= blk_last)
    else $error("rms block counter ran past block length");

  hold_cfg_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && idx == IDX_HOLD_HI |=> filter_flag_hold_count_q[15:8] == $past(pwdata[7:0]))
    else $error("hold count high byte not stored");

  stat_sticky_a : assert property (@(posedge pclk) disable iff (!presetn)
    irq_stat_q[IRQ_P0_SET] && !(wr_en && idx == IDX_IRQ_STAT) |=> irq_stat_q[IRQ_P0_SET])
    else $error("status bit lost without clear");

  three_level_a : assert property (@(posedge pclk) disable iff (!presetn)
    !filter_input_select_q |-> filt_in[0] != FRAC_MINUS1)
    else $error("negative filter input with high-only select");

endmodule : crossing_iir_rms_power_detect

// ==== common/power_detect_pkg.sv ====
// Purpose: constants, register map and field layout of the crossing IIR and RMS power detector
// Assumes: one aligned 32-bit APB word per register, byte address = register index * 4
// Notes:   data fields sit in the low bits except the live status in bits 5:2, upper bits read as zero
// ---------------------------------------------------------------------------
// Operation
// - each IIR threshold is a 16-bit signed 2.14 value, 4000h meaning all crossings and 0800h one eighth
// - each IIR path's filtered crossing result is checked against its own high and low threshold
// - a per-path format bit picks a 1-bit (0) or 2-bit (1) comparator output
// - a filter output above its path's high threshold sets that path's peak flag
// - a peak flag clears only after the filter output stays below the low threshold for the whole hold time
// - the hold time is a 16-bit count in two bytes, counted in sample clock / 8 cycles
// - one enable bit turns the RMS power detector off (0) or on (1)
// - a 5-bit field sets the RMS block length to 2^M sample clock / 8 cycles, M from 0 to 16
// - an input select bit feeds the filter the high comparators alone or a -1/0/+1 three-level value
// - the RMS average power is checked against a 16-bit high and a 16-bit low threshold
// ---------------------------------------------------------------------------
package power_detect_pkg;

  // -------------------------------------------------------------------------
  // register indices
  // -------------------------------------------------------------------------
  localparam logic [7:0] IDX_FILT_SEL   = 8'h0D;
  localparam logic [7:0] IDX_P0_HI_LO   = 8'h0F;
  localparam logic [7:0] IDX_P0_HI_HI   = 8'h10;
  localparam logic [7:0] IDX_P0_LO_LO   = 8'h11;
  localparam logic [7:0] IDX_P0_LO_HI   = 8'h12;
  localparam logic [7:0] IDX_P0_FORMAT  = 8'h13;
  localparam logic [7:0] IDX_P1_HI_LO   = 8'h16;
  localparam logic [7:0] IDX_P1_HI_HI   = 8'h17;
  localparam logic [7:0] IDX_P1_LO_LO   = 8'h18;
  localparam logic [7:0] IDX_P1_LO_HI   = 8'h19;
  localparam logic [7:0] IDX_P1_FORMAT  = 8'h1A;
  localparam logic [7:0] IDX_HOLD_LO    = 8'h1D;
  localparam logic [7:0] IDX_HOLD_HI    = 8'h1E;
  localparam logic [7:0] IDX_RMS_EN     = 8'h20;
  localparam logic [7:0] IDX_RMS_LEN    = 8'h21;
  localparam logic [7:0] IDX_PWR_HI_LO  = 8'h22;
  localparam logic [7:0] IDX_PWR_HI_HI  = 8'h23;
  localparam logic [7:0] IDX_PWR_LO_LO  = 8'h24;
  localparam logic [7:0] IDX_PWR_LO_HI  = 8'h25;
  localparam logic [7:0] IDX_IRQ_STAT   = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h41;
  localparam logic [7:0] IDX_LIVE       = 8'h42;

  // -------------------------------------------------------------------------
  // fields and values
  // -------------------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [15:0] THR_RESET     = 16'h0000;
  localparam logic [15:0] FRAC_ONE      = 16'h4000;
  localparam logic [15:0] FRAC_MINUS1   = 16'hC000;
  localparam logic [15:0] FRAC_EIGHTH   = 16'h0800;
  localparam int          LEN_FIELD_W   = 5;
  localparam logic [4:0]  LEN_EXP_MAX   = 5'h10;
  localparam int          PWR_SHIFT     = 14;
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_P0_SET    = 0;
  localparam int          IRQ_P1_SET    = 1;
  localparam int          IRQ_PWR_HI    = 2;
  localparam int          IRQ_PWR_LO    = 3;
  localparam int          IIR_SHIFT0    = 4;
  localparam int          IIR_SHIFT1    = 6;

endpackage : power_detect_pkg

// ==== rtl/path_compare.sv ====
// Purpose: one IIR path comparator with peak flag and hold-time release
// Assumes: tick marks one sample clock / 8 cycle, filt is valid on tick
// Notes:   output is registered
`timescale 1ns/1ps
module path_compare
  import power_detect_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               tick,
  input  wire logic signed [15:0] filt,
  input  wire logic signed [15:0] upper_limit,
  input  wire logic signed [15:0] lower_limit,
  input  wire logic [15:0]        hold_count,
  input  wire logic               wide_flag_sel,
  output logic                    peak_flag_q,
  output logic [1:0]              flag_out_q
);

  // -------------------------------------------------------------------------
  // comparisons
  // -------------------------------------------------------------------------
  logic        above_hi;
  logic        above_lo;
  logic [15:0] hold_q;

  assign above_hi = filt > upper_limit;
  assign above_lo = filt >= lower_limit;

  // -------------------------------------------------------------------------
  // hold counter and peak flag
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= 16'h0000;
    else if (tick)
    begin
      if (above_lo || !peak_flag_q)
        hold_q <= 16'h0000;
      else if (hold_q != 16'hFFFF)
        hold_q <= hold_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      peak_flag_q <= 1'b0;
    else if (tick)
    begin
      if (above_hi)
        peak_flag_q <= 1'b1;
      else if (!above_lo && hold_q >= hold_count)
        peak_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_out_q <= 2'b00;
    else if (wide_flag_sel)
      flag_out_q <= {peak_flag_q, above_lo};
    else
      flag_out_q <= {1'b0, peak_flag_q};
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  peak_set_a : assert property (@(posedge pclk) disable iff (!presetn)
    tick && above_hi |=> peak_flag_q)
    else $error("peak flag not set after high crossing");

  hold_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
    tick && peak_flag_q && above_lo |=> peak_flag_q && hold_q == 16'h0000)
    else $error("peak flag released while above low threshold");

  narrow_fmt_a : assert property (@(posedge pclk) disable iff (!presetn)
    !wide_flag_sel |=> flag_out_q == {1'b0, $past(peak_flag_q)})
    else $error("narrow format output wrong");

endmodule : path_compare

// ==== verif/crossing_iir_rms_power_detect_tb.sv ====
// Purpose: self-checking bench for the crossing IIR comparators and RMS power detector
// Assumes: zero wait state APB, tick pulses once every 8 pclk
// Notes:   reads are matched by a monitor against a queue of expected words
`timescale 1ns/1ps
module crossing_iir_rms_power_detect_tb
  import power_detect_pkg::*;
;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic               tick = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic [31:0]        d;
  logic               pready, pslverr, power_high_q, power_low_q, irq;
  logic [1:0]         blk_high_hit = 2'h0;
  logic [1:0]         blk_low_hit = 2'h3;
  logic [1:0]         path0_flag_out, path1_flag_out;
  logic signed [15:0] rms_sample = 16'sh0;
  logic [2:0]         tcnt = 3'h0;
  logic [32:0]        exp_q[$];
  logic [32:0]        e;
  integer             num_errors = 0, checks = 0, seed = 32'h0e19, i;
  logic [7:0]         rw_i[9] = '{IDX_P0_HI_LO, IDX_P0_LO_HI, IDX_P1_HI_HI, IDX_P1_LO_LO, IDX_HOLD_LO,
                                  IDX_HOLD_HI, IDX_P0_FORMAT, IDX_RMS_EN, IDX_RMS_LEN};
  logic [31:0]        rw_m[9] = '{32'hFF, 32'hFF, 32'h7F, 32'hFF, 32'hFF, 32'hFF, 32'h1, 32'h1, 32'h1F};
  logic [7:0]         cf_i[14] = '{IDX_P0_HI_LO, IDX_P0_HI_HI, IDX_P0_LO_LO, IDX_P0_LO_HI, IDX_HOLD_LO, IDX_HOLD_HI,
                                   IDX_P0_FORMAT, IDX_IRQ_MASK, IDX_P1_HI_HI, IDX_RMS_EN,
                                   IDX_PWR_HI_HI, IDX_PWR_LO_HI, IDX_RMS_LEN, IDX_RMS_EN};
  logic [31:0]        cf_d[14] = '{32'h0, 32'h20, 32'h0, 32'h10, 32'h40, 32'h0, 32'h1, 32'h1, 32'h20, 32'h0,
                                   32'h10, 32'h08, 32'h2, 32'h1};

  crossing_iir_rms_power_detect uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick(tick), .blk_high_hit(blk_high_hit), .blk_low_hit(blk_low_hit), .rms_sample(rms_sample),
    .path0_flag_out(path0_flag_out), .path1_flag_out(path1_flag_out), .power_high_q(power_high_q),
    .power_low_q(power_low_q), .irq(irq));

  always #2.5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7);
  end

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] expv);
    checks = checks + 1;
    if (seen !== expv)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask : chk

  task automatic give_verdict();
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [32:0] ex);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    if (!wr)
      exp_q.push_back(ex);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input int lo, input int hi);
    for (int k = lo; k <= hi; k++)
      apb(1'b1, cf_i[k], cf_d[k], 33'h0);
  endtask : cfg

  task automatic ticks(input int n);
    repeat (n * 8) @(posedge pclk);
  endtask : ticks

  // read monitor
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      e = exp_q.pop_front();
      chk("read", {pslverr, prdata}, e);
    end
  end

  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 9; i++)
      apb(1'b0, rw_i[i], 32'h0, 33'h0);
    for (i = 0; i < 9; i++)
    begin
      d = $random(seed) & rw_m[i];
      apb(1'b1, rw_i[i], d, 33'h0);
      apb(1'b0, rw_i[i], 32'h0, {1'b0, d});
    end
    apb(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
    cfg(0, 9);
    blk_high_hit <= 2'h1;
    for (i = 0; i < 400 && path0_flag_out[1] !== 1'b1; i++)
      @(posedge pclk);
    chk("path0 flag wide", {31'h0, path0_flag_out}, 33'h3);
    chk("irq", {32'h0, irq}, 33'h1);
    apb(1'b0, IDX_IRQ_STAT, 32'h0, 33'h1);
    apb(1'b0, IDX_LIVE, 32'h0, 33'h4);
    apb(1'b1, IDX_IRQ_STAT, 32'h1, 33'h0);
    @(posedge pclk);
    chk("irq cleared", {32'h0, irq}, 33'h0);
    apb(1'b1, IDX_P0_FORMAT, 32'h0, 33'h0);
    ticks(1);
    chk("path0 flag narrow", {31'h0, path0_flag_out}, 33'h1);
    blk_high_hit <= 2'h0;
    ticks(40);
    chk("path0 flag held", {31'h0, path0_flag_out}, 33'h1);
    ticks(80);
    chk("path0 flag released", {31'h0, path0_flag_out}, 33'h0);
    rms_sample <= 16'sh4000;
    cfg(10, 13);
    for (i = 0; i < 200 && power_high_q !== 1'b1; i++)
      @(posedge pclk);
    chk("power high", {32'h0, power_high_q}, 33'h1);
    chk("power low", {32'h0, power_low_q}, 33'h0);
    apb(1'b1, IDX_RMS_EN, 32'h0, 33'h0);
    ticks(1);
    chk("power off", {32'h0, power_high_q}, 33'h0);
    apb(1'b1, IDX_P1_LO_LO, 32'h0, 33'h0);
    apb(1'b1, IDX_P1_FORMAT, 32'h1, 33'h0);
    ticks(2);
    chk("path1 flag wide", {31'h0, path1_flag_out}, 33'h1);
    apb(1'b1, IDX_FILT_SEL, 32'h1, 33'h0);
    blk_low_hit <= 2'h1;
    ticks(4);
    chk("path1 three level", {31'h0, path1_flag_out}, 33'h0);
    give_verdict();
  end
endmodule : crossing_iir_rms_power_detect_tb
